// ==== common/tocr_pkg.sv ====
// Shared constants and carrier types for the timing output channel router
package tocr_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int TOCR_CHANNELS = 16;
    localparam int TOCR_OUTPUTS = 4;
    localparam int TOCR_SEL_W = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic TOCR_MODE_RESET = 1'h0;
    localparam logic [15:0] TOCR_MAP_RESET = 16'h3210;
    localparam logic [15:0] TOCR_DISP_RESET = 16'h3210;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {
        TOCR_DISPLAY_LINKED,
        TOCR_FIXED
    } tocr_mode_t;

    // One mapping command: digit k targets output k; keep_k means "-"
    typedef struct packed {
        logic [TOCR_OUTPUTS-1:0] keep;
        logic [TOCR_OUTPUTS*TOCR_SEL_W-1:0] digits;
    } tocr_map_cmd_t;

endpackage : tocr_pkg

// ==== hdl/tocr_slot.sv ====
// One timing output slot: channel selector and sixteen-to-one mux
`timescale 1ns/1ps
`default_nettype none
module tocr_slot
    import tocr_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Selection
    input wire logic fixed_mode,
    input wire logic [3:0] reset_sel,
    input wire logic [3:0] display_sel,
    input wire logic [3:0] cmd_sel,
    input wire logic cmd_valid,
    // Channel signals
    input wire logic [15:0] chan_timing,
    input wire logic [15:0] chan_moving,
    // Result
    output logic [3:0] fixed_sel,
    output logic pending,
    output logic timing_out
);

    typedef struct packed {
        logic [3:0] sel;
        logic [3:0] want;
        logic pend;
        logic out;
    } tocr_slot_state_t;

    tocr_slot_state_t s_q, s_d;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (cmd_valid) begin
            s_d.want = cmd_sel;
            s_d.pend = 1'b1;
        end
        // Both old and new channel must be stopped
        if (s_d.pend && !chan_moving[s_q.sel] && !chan_moving[s_d.want]) begin
            s_d.sel = s_d.want;
            s_d.pend = 1'b0;
        end
        if (fixed_mode) begin
            s_d.out = chan_timing[s_q.sel];
        end else begin
            s_d.out = chan_timing[display_sel];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '{sel: reset_sel, want: reset_sel, pend: 1'b0, out: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Selector holds its reset channel until the first applied remap
    assign fixed_sel = s_q.sel;
    assign pending = s_q.pend;
    assign timing_out = s_q.out;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_slot_fixed_out;
        @(posedge ref_clk) disable iff (rst)
        fixed_mode |=> timing_out == $past(chan_timing[s_q.sel]);
    endproperty
    a_slot_fixed_out: assert property (p_slot_fixed_out)
        else $error("fixed output does not follow its channel");

    property p_slot_hold_moving;
        @(posedge ref_clk) disable iff (rst)
        chan_moving[s_q.sel] |=> s_q.sel == $past(s_q.sel);
    endproperty
    a_slot_hold_moving: assert property (p_slot_hold_moving)
        else $error("selector changed while old channel moved");

endmodule // tocr_slot
`default_nettype wire

// ==== hdl/timing_output_channel_router.sv ====
// Timing output channel router: sixteen channels onto four timing pins
// What this block does
// - Two routing modes, display-linked or fixed, chosen by host command.
// - Display-linked: each output follows the channel shown at its place.
// - Fixed: each output carries its assigned channel even if not shown.
// - Mode change is applied only when all channel motors are stopped.
// - A dash digit leaves that output's assignment unchanged.
// - Remap applies only when old and new channel are both stopped.
// - Stored mapping readable always; affects outputs only in fixed mode.
// - Mapping readback is four channel digits, first output to fourth.
// - Active routing mode is reported on request.
// - Fixed mode: display channel may change without touching routing.
`timescale 1ns/1ps
`default_nettype none
module timing_output_channel_router
    import tocr_pkg::*;
#(
    // Sizes; the logic serves only the defaults
    parameter int CHANNELS = TOCR_CHANNELS,
    parameter int OUTPUTS = TOCR_OUTPUTS,
    parameter int SEL_W = TOCR_SEL_W
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Channel status
    input wire logic [15:0] chan_timing,
    input wire logic [15:0] chan_moving,
    // Display positions, channel number shown at each place
    input wire logic [15:0] display_map,
    // Host commands
    input wire logic route_mode_command,
    input wire logic route_mode_fixed,
    input wire logic route_map_command,
    input wire tocr_map_cmd_t route_map_arg,
    // Readback
    output logic fixed_mode_active,
    output logic mode_pending,
    output logic [15:0] route_map_readback,
    output logic map_pending,
    // Timing pins
    output logic timing_out_a,
    output logic timing_out_b,
    output logic timing_out_c,
    output logic timing_out_d
);

    typedef struct packed {
        tocr_mode_t mode;
        tocr_mode_t want;
        logic pend;
        logic [15:0] map_rb;
        logic map_pend;
        logic [3:0] outs;
        logic fixed;
    } tocr_state_t;

    tocr_state_t s_q, s_d;

    logic [3:0] slot_out;
    logic [3:0] slot_pend;
    logic [3:0] slot_cmd;
    logic [15:0] slot_sel;

    // ------------------------------------------------------------------
    // Size check
    // ------------------------------------------------------------------
    // Port widths and slots are built for sixteen channels on four pins
    if (CHANNELS != TOCR_CHANNELS || OUTPUTS != TOCR_OUTPUTS ||
            SEL_W != TOCR_SEL_W) begin : g_bad_size
        $error("router serves only sixteen channels on four pins");
    end

    // ------------------------------------------------------------------
    // Per-output slots
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < OUTPUTS; g++) begin : g_slot
            // A dash keeps the old digit; no request raised for it
            assign slot_cmd[g] = route_map_command && !route_map_arg.keep[g];
            tocr_slot u_slot (
                .ref_clk(ref_clk),
                .rst(rst),
                .fixed_mode(s_q.mode == TOCR_FIXED),
                .reset_sel(TOCR_MAP_RESET[g*4 +: 4]),
                .display_sel(display_map[g*4 +: 4]),
                .cmd_sel(route_map_arg.digits[g*4 +: 4]),
                .cmd_valid(slot_cmd[g]),
                .chan_timing(chan_timing),
                .chan_moving(chan_moving),
                .fixed_sel(slot_sel[g*4 +: 4]),
                .pending(slot_pend[g]),
                .timing_out(slot_out[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Mode control and readback
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (route_mode_command) begin
            s_d.want = route_mode_fixed ? TOCR_FIXED : TOCR_DISPLAY_LINKED;
            s_d.pend = 1'b1;
        end
        if (s_d.pend && chan_moving == 16'h0000) begin
            s_d.mode = s_d.want;
            s_d.pend = 1'b0;
        end
        s_d.map_rb = slot_sel;
        s_d.map_pend = |slot_pend;
        s_d.outs = slot_out;
        s_d.fixed = (s_q.mode == TOCR_FIXED);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '{mode: tocr_mode_t'(TOCR_MODE_RESET),
                     want: tocr_mode_t'(TOCR_MODE_RESET),
                     pend: 1'b0, map_rb: TOCR_MAP_RESET, map_pend: 1'b0,
                     outs: 4'h0, fixed: TOCR_MODE_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign fixed_mode_active = s_q.fixed;
    assign mode_pending = s_q.pend;
    assign route_map_readback = s_q.map_rb;
    assign map_pending = s_q.map_pend;
    assign timing_out_a = s_q.outs[0];
    assign timing_out_b = s_q.outs[1];
    assign timing_out_c = s_q.outs[2];
    assign timing_out_d = s_q.outs[3];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_mode_hold;
        @(posedge ref_clk) disable iff (rst)
        chan_moving != 16'h0000 |=> s_q.mode == $past(s_q.mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("mode changed while a motor moved");

    property p_mode_apply;
        @(posedge ref_clk) disable iff (rst)
        route_mode_command && route_mode_fixed && chan_moving == 16'h0000
        |=> s_q.mode == TOCR_FIXED ##1 fixed_mode_active;
    endproperty
    a_mode_apply: assert property (p_mode_apply)
        else $error("fixed mode not applied when stopped");

    property p_linked_out;
        @(posedge ref_clk) disable iff (rst)
        s_q.mode == TOCR_DISPLAY_LINKED && $stable(s_q.mode)
        |=> ##1 timing_out_a == $past(chan_timing[display_map[3:0]], 2);
    endproperty
    a_linked_out: assert property (p_linked_out)
        else $error("linked output does not follow display");

    property p_dash_keep;
        @(posedge ref_clk) disable iff (rst)
        route_map_command && route_map_arg.keep[0] && !slot_pend[0]
        |=> slot_sel[3:0] == $past(slot_sel[3:0]);
    endproperty
    a_dash_keep: assert property (p_dash_keep)
        else $error("dash digit changed assignment");

    property p_map_apply;
        @(posedge ref_clk) disable iff (rst)
        route_map_command && !route_map_arg.keep[1] && chan_moving == 16'h0000
        ##1 chan_moving == 16'h0000 && !route_map_command
        |=> slot_sel[7:4] == $past(route_map_arg.digits[7:4], 2) ##1
            route_map_readback[7:4] == $past(route_map_arg.digits[7:4], 3);
    endproperty
    a_map_apply: assert property (p_map_apply)
        else $error("remap not applied at first stopped cycle");

    property p_mode_wait_moving;
        @(posedge ref_clk) disable iff (rst)
        route_mode_command && chan_moving != 16'h0000
        |=> mode_pending;
    endproperty
    a_mode_wait_moving: assert property (p_mode_wait_moving)
        else $error("mode request not held while a motor moved");

    property p_mode_linked_apply;
        @(posedge ref_clk) disable iff (rst)
        route_mode_command && !route_mode_fixed && chan_moving == 16'h0000
        |=> s_q.mode == TOCR_DISPLAY_LINKED ##1 !fixed_mode_active;
    endproperty
    a_mode_linked_apply: assert property (p_mode_linked_apply)
        else $error("linked mode not applied when stopped");

    property p_fixed_out_d;
        @(posedge ref_clk) disable iff (rst)
        s_q.mode == TOCR_FIXED
        |=> ##1 timing_out_d == $past(chan_timing[slot_sel[15:12]], 2);
    endproperty
    a_fixed_out_d: assert property (p_fixed_out_d)
        else $error("fixed output d does not follow its channel");

    property p_readback_a;
        @(posedge ref_clk) disable iff (rst)
        route_map_command && !route_map_arg.keep[0] && chan_moving == 16'h0000
        |=> ##1 route_map_readback[3:0] == $past(route_map_arg.digits[3:0], 2);
    endproperty
    a_readback_a: assert property (p_readback_a)
        else $error("readback of output a not updated");

    c_to_fixed: cover property (@(posedge ref_clk) disable iff (rst)
        $rose(fixed_mode_active));
    c_to_linked: cover property (@(posedge ref_clk) disable iff (rst)
        $fell(fixed_mode_active));
    c_remap_fixed: cover property (@(posedge ref_clk) disable iff (rst)
        fixed_mode_active && $fell(map_pending));
    c_mode_wait: cover property (@(posedge ref_clk) disable iff (rst)
        mode_pending [*3]);
    c_map_wait: cover property (@(posedge ref_clk) disable iff (rst)
        $fell(map_pending));

endmodule // timing_output_channel_router
`default_nettype wire

// ==== test/tocr_host.sv ====
// Host model that issues routing mode and mapping commands
`timescale 1ns/1ps
`default_nettype none
module tocr_host
    import tocr_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Commands
    output logic route_mode_command,
    output logic route_mode_fixed,
    output logic route_map_command,
    output tocr_map_cmd_t route_map_arg
);
    initial begin
        route_mode_command = 1'h0;
        route_mode_fixed = 1'h0;
        route_map_command = 1'h0;
        route_map_arg = '0;
    end
    task automatic send_mode(input logic fixed);
        @(posedge ref_clk);
        route_mode_command <= 1'h1;
        route_mode_fixed <= fixed;
        @(posedge ref_clk);
        route_mode_command <= 1'h0;
        route_mode_fixed <= ~fixed;
    endtask
    // Digit of output a in [3:0]; callers never repeat a channel
    task automatic send_map(input logic [3:0] keep, input logic [15:0] dig);
        @(posedge ref_clk);
        route_map_command <= 1'h1;
        route_map_arg <= '{keep: keep, digits: dig};
        @(posedge ref_clk);
        route_map_command <= 1'h0;
        route_map_arg <= '{keep: ~keep, digits: ~dig};
    endtask
endmodule // tocr_host
`default_nettype wire

// ==== test/timing_output_channel_router_tb_top.sv ====
// Self-checking testbench for the timing output channel router
`timescale 1ns/1ps
`default_nettype none
module timing_output_channel_router_tb_top;
    import tocr_pkg::*;
    logic ref_clk, rst;
    logic [15:0] chan_timing, chan_moving, display_map, route_map_readback;
    logic route_mode_command, route_mode_fixed, route_map_command;
    tocr_map_cmd_t route_map_arg;
    logic fixed_mode_active, mode_pending, map_pending;
    logic [3:0] pins;
    int fails, comparisons, cycles;

    timing_output_channel_router dut (.ref_clk(ref_clk), .rst(rst),
        .chan_timing(chan_timing), .chan_moving(chan_moving),
        .display_map(display_map), .route_mode_command(route_mode_command),
        .route_mode_fixed(route_mode_fixed),
        .route_map_command(route_map_command), .route_map_arg(route_map_arg),
        .fixed_mode_active(fixed_mode_active), .mode_pending(mode_pending),
        .route_map_readback(route_map_readback), .map_pending(map_pending),
        .timing_out_a(pins[0]), .timing_out_b(pins[1]),
        .timing_out_c(pins[2]), .timing_out_d(pins[3]));
    tocr_host host (.ref_clk(ref_clk), .route_mode_command(route_mode_command),
        .route_mode_fixed(route_mode_fixed),
        .route_map_command(route_map_command), .route_map_arg(route_map_arg));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic end_sim;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic set_moving(input logic [15:0] v);
        @(posedge ref_clk);
        chan_moving <= v;
    endtask
    // Lights one channel per output and sees only that output rise
    task automatic pins_follow(input logic [15:0] chans);
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            chan_timing <= 16'h0001 << chans[4*k+:4];
            settle();
            check({12'h0, pins}, 16'h0001 << k);
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        check(route_map_readback, TOCR_MAP_RESET);
        check({15'h0, fixed_mode_active}, 16'h0000);
    endtask
    task automatic t_map_linked;
        pins_follow(16'h9C5A);
        host.send_map(4'h4, 16'h7E41);
        settle();
        check(route_map_readback, 16'h7241);
        pins_follow(16'h9C5A);
    endtask
    task automatic t_mode_wait;
        set_moving(16'h0100);
        host.send_mode(1'h1);
        settle();
        check({14'h0, fixed_mode_active, mode_pending}, 16'h0001);
        set_moving(16'h0000);
        settle();
        check({14'h0, fixed_mode_active, mode_pending}, 16'h0002);
    endtask
    task automatic t_fixed;
        @(posedge ref_clk);
        display_map <= 16'h0123;
        pins_follow(16'h7241);
        check({15'h0, fixed_mode_active}, 16'h0001);
    endtask
    task automatic t_remap;
        set_moving(16'h0080);
        host.send_map(4'h7, 16'hB000);
        settle();
        check({15'h0, map_pending}, 16'h0001);
        set_moving(16'h0800);
        settle();
        check(route_map_readback, 16'h7241);
        set_moving(16'h0000);
        settle();
        check(route_map_readback, 16'hB241);
        pins_follow(16'hB241);
    endtask
    task automatic t_back_linked;
        host.send_mode(1'h0);
        settle();
        check({15'h0, fixed_mode_active}, 16'h0000);
        pins_follow(16'h0123);
    endtask

    // ------------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        rst = 1'b1;
        chan_timing = 16'h0000;
        chan_moving = 16'h0000;
        display_map = 16'h9C5A;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        settle();
        t_reset();
        t_map_linked();
        t_mode_wait();
        t_fixed();
        t_remap();
        t_back_linked();
        end_sim();
    end
endmodule // timing_output_channel_router_tb_top
`default_nettype wire
